// File: design/safety_state_sequencer.sv
// Module: operating-state sequencer with APB register access
`timescale 1ns/100ps
module safety_state_sequencer
  import seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Error and reboot pins, asynchronous
  input  wire logic        fatal_err_pin,
  input  wire logic        comm_err_pin,
  input  wire logic        sf_err_pin,
  input  wire logic        reboot_pin,
  // State and link status
  output seq_state_e       state,
  output logic             operator_ack_request
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Fourth stage keeps the level; a one-cycle glitch never counts
  logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg   <= 4'h0;
      s2_reg   <= 4'h0;
      s3_reg   <= 4'h0;
      filt_reg <= 4'h0;
    end else begin
      s1_reg   <= {reboot_pin, fatal_err_pin, comm_err_pin, sf_err_pin};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end
  // Change accepted only when second and third stages agree
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : filt_reg[i];
    end
  end

  // Sampled vector order: reboot, fatal, comm, sf
  err_s err;
  logic reboot_pin_s;
  assign err          = '{fatal: filt_reg[2], comm: filt_reg[1], sf: filt_reg[0]};
  assign reboot_pin_s = filt_reg[3];

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] ack_mode_reg, ack_mode_next;
  host_cmd_s  host_reg, host_next;
  logic       reboot_sw, local_ack, wr, rd;

  // No wait states: every register answers in its access cycle
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_CTRL ||
                   paddr == ADDR_STATUS || paddr == ADDR_HOST);

  // Reboot and local ack are one-cycle pulses of the write itself
  always_comb begin
    ack_mode_next = ack_mode_reg;
    host_next     = host_reg;
    reboot_sw     = 1'b0;
    local_ack     = 1'b0;
    if (wr && paddr == ADDR_CTRL) begin
      ack_mode_next = pwdata[CTRL_ACK_MODE_LSB +: 2];
      reboot_sw     = pwdata[CTRL_REBOOT_BIT];
      local_ack     = pwdata[CTRL_LOCAL_ACK];
    end
    if (wr && paddr == ADDR_HOST) begin
      host_next.passivate_command    = pwdata[HOST_PASSIVATE];
      host_next.operator_ack_command = pwdata[HOST_OP_ACK];
    end
  end

  // Read data taken in the setup cycle, stands through the access
  logic [31:0] prdata_next;
  always_comb begin
    prdata_next = 32'h0;
    if (rd && paddr == ADDR_CTRL)
      prdata_next[CTRL_ACK_MODE_LSB +: 2] = ack_mode_reg;
    if (rd && paddr == ADDR_STATUS)
      prdata_next = {24'h0, 1'b0, err.fatal, err.comm, err.sf,
                     operator_ack_request, state};
    if (rd && paddr == ADDR_HOST)
      prdata_next = {30'h0, host_reg.operator_ack_command,
                     host_reg.passivate_command};
  end

  // Edge of the registered host bit: a held bit acknowledges once
  logic ack_rise, ack_prev_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_mode_reg <= CTRL_RESET_MODE;
      host_reg     <= '0;
      prdata       <= 32'h0;
      ack_prev_reg <= 1'b0;
    end else begin
      ack_mode_reg <= ack_mode_next;
      host_reg     <= host_next;
      prdata       <= prdata_next;
      ack_prev_reg <= host_reg.operator_ack_command;
    end
  end
  assign ack_rise = host_reg.operator_ack_command && !ack_prev_reg;

  // ****************************************
  // Acknowledge source
  // ****************************************
  logic ack_ok;
  always_comb begin
    unique case (ack_mode_reg)
      ACK_LOCAL: ack_ok = local_ack;
      ACK_LINK:  ack_ok = ack_rise;
      ACK_AUTO:  ack_ok = 1'b1;
      default:   ack_ok = 1'b0;
    endcase
  end

  // ****************************************
  // State machine
  // ****************************************
  seq_state_e state_reg, state_next;
  logic       oar_reg, oar_next, reboot;
  assign reboot = reboot_sw || reboot_pin_s;
  assign state  = state_reg;
  assign operator_ack_request = oar_reg;

  // Reboot outranks everything; fatal next, then link errors
  always_comb begin
    state_next = state_reg;
    oar_next   = oar_reg;
    if (reboot) begin
      state_next = ST_STARTUP;
      oar_next   = 1'b0;
    end else if (state_reg != ST_FAILSAFE && err.fatal) begin
      state_next = ST_FAILSAFE;
      oar_next   = 1'b0;
    end else if (state_reg != ST_FAILSAFE && err.comm) begin
      // Plain passivation holds for as long as the link error lasts
      state_next = ST_PASS;
      oar_next   = 1'b0;
    end else begin
      unique case (state_reg)
        ST_STARTUP: state_next = ST_CMD;
        ST_OPER: begin
          if (host_reg.passivate_command)
            state_next = ST_CMD;
          else if (err.sf)
            state_next = ST_REINT;
        end
        ST_REINT: begin
          if (host_reg.passivate_command)
            state_next = ST_CMD;
          else if (!err.sf && ack_ok)
            state_next = ST_OPER;
        end
        ST_PASS: begin
          if (host_reg.passivate_command)
            state_next = ST_CMD;
          else begin
            state_next = ST_ACKREQ;
            oar_next   = 1'b1;
          end
        end
        ST_ACKREQ: begin
          if (host_reg.passivate_command) begin
            state_next = ST_CMD;
            oar_next   = 1'b0;
          end else if (ack_rise) begin
            state_next = err.sf ? ST_REINT : ST_OPER;
            oar_next   = 1'b0;
          end
        end
        ST_CMD: begin
          if (!host_reg.passivate_command)
            state_next = err.sf ? ST_REINT : ST_OPER;
        end
        // Only a reboot leaves; link errors are ignored here
        ST_FAILSAFE: state_next = ST_FAILSAFE;
        default:     state_next = ST_STARTUP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_STARTUP;
      oar_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      oar_reg   <= oar_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_startup_leaves: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_STARTUP && !reboot && !err.fatal && !err.comm
    |=> state_reg == ST_CMD) else $error("start-up did not exit");
  chk_reboot_start: assert property (@(posedge clk) disable iff (!rst_b)
    reboot |=> state_reg == ST_STARTUP)
    else $error("reboot ignored");
  chk_failsafe_hold: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_FAILSAFE && !reboot |=> state_reg == ST_FAILSAFE)
    else $error("fail-safe left");
  chk_fatal_wins: assert property (@(posedge clk) disable iff (!rst_b)
    err.fatal && !reboot |=> state_reg == ST_FAILSAFE)
    else $error("fatal not taken");
  chk_comm_pass: assert property (@(posedge clk) disable iff (!rst_b)
    err.comm && !err.fatal && !reboot && state_reg != ST_FAILSAFE
    |=> state_reg == ST_PASS)
    else $error("comm error missed");
  chk_sf_reint: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_OPER && err.sf && !err.fatal && !err.comm && !reboot
    && !host_reg.passivate_command |=> state_reg == ST_REINT)
    else $error("sf error missed");
  chk_oar_in_ackreq: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_ACKREQ |-> oar_reg)
    else $error("ack request flag low");
  chk_cmd_enter: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_OPER && host_reg.passivate_command && !err.fatal
    && !err.comm && !reboot |=> state_reg == ST_CMD)
    else $error("passivate ignored");
  chk_cmd_exit: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_CMD && !host_reg.passivate_command && !err.sf
    && !err.fatal && !err.comm && !reboot |=> state_reg == ST_OPER)
    else $error("command exit missed");
  chk_cmd_hold: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_CMD && host_reg.passivate_command && !err.fatal
    && !err.comm && !reboot |=> state_reg == ST_CMD)
    else $error("command state left early");
  chk_startup_comm: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_STARTUP && err.comm && !err.fatal && !reboot
    |=> state_reg == ST_PASS)
    else $error("start-up comm error missed");
  chk_comm_first: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_OPER && err.comm && !err.fatal && !reboot
    && (err.sf || host_reg.passivate_command) |=> state_reg == ST_PASS)
    else $error("comm error outranked");
  chk_failsafe_exit: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_FAILSAFE && reboot |=> state_reg == ST_STARTUP)
    else $error("fail-safe reboot ignored");

  // ****************************************
  // Checks on exits from the Safe sub-states
  // ****************************************
  chk_pass_hold: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PASS && err.comm && !err.fatal && !reboot
    |=> state_reg == ST_PASS)
    else $error("passivation left early");
  chk_pass_cmd: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PASS && !err.comm && !err.fatal && !reboot
    && host_reg.passivate_command |=> state_reg == ST_CMD)
    else $error("passivation to command missed");
  chk_pass_ackreq: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PASS && !err.comm && !err.fatal && !reboot
    && !host_reg.passivate_command |=> state_reg == ST_ACKREQ && oar_reg)
    else $error("ack request not raised");
  chk_oar_only_ackreq: assert property (@(posedge clk) disable iff (!rst_b)
    oar_reg |-> state_reg == ST_ACKREQ)
    else $error("ack request flag stray");
  chk_ackreq_oper: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_ACKREQ && ack_rise && !err.sf && !err.fatal && !err.comm
    && !reboot && !host_reg.passivate_command |=> state_reg == ST_OPER)
    else $error("ack edge ignored");
  chk_ackreq_reint: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_ACKREQ && ack_rise && err.sf && !err.fatal && !err.comm
    && !reboot && !host_reg.passivate_command |=> state_reg == ST_REINT)
    else $error("ack edge with sf error");
  chk_ackreq_wait: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_ACKREQ && !ack_rise && !err.fatal && !err.comm
    && !reboot && !host_reg.passivate_command |=> state_reg == ST_ACKREQ)
    else $error("ack request left without edge");
  chk_reint_exit: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_REINT && !err.sf && ack_ok && !err.fatal && !err.comm
    && !reboot && !host_reg.passivate_command |=> state_reg == ST_OPER)
    else $error("reintegration exit missed");
  chk_reint_hold: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_REINT && (err.sf || !ack_ok) && !err.fatal && !err.comm
    && !reboot && !host_reg.passivate_command |=> state_reg == ST_REINT)
    else $error("reintegration left early");
  chk_local_ack: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_REINT && ack_mode_reg == ACK_LOCAL && !local_ack
    |=> state_reg != ST_OPER)
    else $error("local ack mode bypassed");

endmodule : safety_state_sequencer

// File: inc/seq_pkg.sv
// Package: states, registers and field layout of the safety state sequencer
// Notes on behaviour
// - Clean start-up leaves Start-up for passivation by command.
// - Power cycle or reboot returns every non-fail state to Start-up.
// - Fail-safe is left only to Start-up, only by power cycle or reboot.
// - Fatal self-test failure moves any running state to Fail-safe.
// - Communication error right after Start-up enters plain passivation.
// - Link error in Operational, command or ack request enters passivation.
// - Safety-function error in Operational enters reintegration state.
// - Ack taken locally, over the link or automatically, per mode.
// - Reintegration returns to Operational once errors cleared and acked.
// - Passivation command 1 in Operational enters passivation by command.
// - Passivation, error cleared, command 1: go to passivation by command.
// - Plain passivation, error cleared and command 0, raises ack request.
// - Operator-ack edge in ack request: Operational if no errors remain.
// - Command state returns to Operational when error-free and command 0.
package seq_pkg;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    ST_STARTUP  = 3'h0,
    ST_CMD      = 3'h1,
    ST_OPER     = 3'h3,
    ST_REINT    = 3'h2,
    ST_PASS     = 3'h6,
    ST_ACKREQ   = 3'h7,
    ST_FAILSAFE = 3'h5
  } seq_state_e;

  // ****************************************
  // Acknowledge modes
  // ****************************************
  localparam logic [1:0] ACK_LOCAL = 2'h0;
  localparam logic [1:0] ACK_LINK  = 2'h1;
  localparam logic [1:0] ACK_AUTO  = 2'h2;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_HOST   = 12'h008;

  localparam int CTRL_ACK_MODE_LSB = 0;
  localparam int CTRL_REBOOT_BIT   = 4;
  localparam int CTRL_LOCAL_ACK    = 5;
  localparam int HOST_PASSIVATE    = 0;
  localparam int HOST_OP_ACK       = 1;
  localparam logic [1:0] CTRL_RESET_MODE = 2'h1;

  // Host command bits after sampling
  typedef struct packed {
    logic passivate_command;
    logic operator_ack_command;
  } host_cmd_s;

  // Error inputs after sampling
  typedef struct packed {
    logic fatal;
    logic comm;
    logic sf;
  } err_s;

endpackage : seq_pkg

// File: verif/fhost_model.sv
// Safety PLC host model: APB master writing host command bits
`timescale 1ns/100ps
module fhost_model (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // ****************************************
  // One transfer; passivate and ack bits ride on HOST writes
  // ****************************************
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Bench timeout ends a hang here
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : fhost_model

// File: verif/tb.sv
// Testbench: scenario run against a reference state model
`timescale 1ns/100ps
module tb import seq_pkg::*; ;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic        fatal_err_pin, comm_err_pin, sf_err_pin, reboot_pin, err;
  seq_state_e  state;
  logic        operator_ack_request;
  bit          f, c, e, p_cmd;
  int          n_errors, samples_checked, cyc, exp_st, mode;
  integer      seed = 32'hf60102db;

  safety_state_sequencer safety_state_sequencer_i (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fatal_err_pin(fatal_err_pin), .comm_err_pin(comm_err_pin),
    .sf_err_pin(sf_err_pin), .reboot_pin(reboot_pin), .state(state),
    .operator_ack_request(operator_ack_request));
  fhost_model host_i (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ****************************************
  // Reference model; fatal checked before comm, comm before the rest
  // ****************************************
  function automatic int model(int s, bit f, c, e, p, ak, ok);
    if (f || s == 5) return 5;
    if (c) return 6;
    case (s)
      0: return 1;
      3: return p ? 1 : (e ? 2 : 3);
      1: return p ? 1 : (e ? 2 : 3);
      6: return p ? 1 : 7;
      7: return p ? 1 : (ak ? (e ? 2 : 3) : 7);
      2: return p ? 1 : ((!e && ok) ? 3 : 2);
      default: return s;
    endcase
  endfunction : model

  task cmp_state;
    samples_checked++;
    if (state !== seq_state_e'(exp_st[2:0]) ||
        operator_ack_request !== (exp_st == 7)) begin
      n_errors++;
      $display("wrong value state exp %0d got %0d flag %b", exp_st, state,
               operator_ack_request);
    end
  endtask : cmp_state

  task cmp_word(input string nm, input logic [31:0] ex, got);
    samples_checked++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask : cmp_word

  // Chained steps resolve in a few passes; ack only counts once
  task settle(input bit ak, input bit ok);
    int i;
    repeat (10) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      exp_st = model(exp_st, f, c, e, p_cmd, ak, ok || mode == 2);
      ak = 0;
      ok = 0;
    end
    #1 cmp_state();
  endtask : settle

  task pin(input bit nf, nc, ne);
    @(posedge clk);
    fatal_err_pin <= nf;
    comm_err_pin  <= nc;
    sf_err_pin    <= ne;
    {f, c, e} = {nf, nc, ne};
  endtask : pin

  task host(input bit p, input bit a);
    p_cmd = p;
    host_i.xfer(1'b1, ADDR_HOST, (32'(p) << HOST_PASSIVATE) |
                (32'(a) << HOST_OP_ACK), rd, err);
  endtask : host

  task ctrl(input logic [31:0] d);
    mode = int'(d[1:0]);
    host_i.xfer(1'b1, ADDR_CTRL, d, rd, err);
  endtask : ctrl

  task final_report;
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    rst_b = 1'b0;
    {fatal_err_pin, comm_err_pin, sf_err_pin, reboot_pin} = 4'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    exp_st = 1;
    mode   = 1;
    @(posedge clk);
    #1 cmp_state();
    host_i.xfer(1'b0, ADDR_CTRL, 32'h0, rd, err);
    cmp_word("ctrl reset", 32'(CTRL_RESET_MODE), rd);
    cmp_word("ctrl err", 32'h0, {31'h0, err});
    host(1, 0); settle(0, 0);
    host(0, 0); settle(0, 0);
    host(1, 0); settle(0, 0);
    host(0, 0); settle(0, 0);
    pin(0, 1, 0); settle(0, 0);
    pin(0, 0, 0); settle(0, 0);
    host_i.xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    cmp_word("status", 32'h0000000f, rd);
    host(0, 1); settle(1, 0);
    ctrl(32'h0);
    pin(0, 0, 1); settle(0, 0);
    pin(0, 0, 0); settle(0, 0);
    ctrl(32'h20); settle(0, 1);
    ctrl(32'h2);
    pin(0, 0, 1); settle(0, 0);
    pin(0, 0, 0); settle(0, 0);
    host(1, 0); settle(0, 0);
    pin(0, 1, 0); settle(0, 0);
    pin(0, 0, 0); settle(0, 0);
    host(0, 0); settle(0, 0);
    pin(1, 1, 0); settle(0, 0);
    pin(0, 0, 0); settle(0, 0);
    host(1, 0); settle(0, 0);
    ctrl(32'h12); exp_st = 0; settle(0, 0);
    pin(0, 1, 0); settle(0, 0);
    @(posedge clk) reboot_pin <= 1'b1;
    repeat (2) @(posedge clk);
    reboot_pin <= 1'b0;
    exp_st = 0;
    settle(0, 0);
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 exp_st = 0;
    cmp_state();
    @(posedge clk) rst_b <= 1'b1;
    p_cmd = 1'b0;
    mode  = 1;
    settle(0, 0);
    host_i.xfer(1'b0, ADDR_CTRL, 32'h0, rd, err);
    cmp_word("ctrl after reset", 32'(CTRL_RESET_MODE), rd);
    r = $random(seed);
    host_i.xfer(1'b0, {r[11:4] | 8'h01, 4'h0}, r, rd, err);
    cmp_word("unmapped err", 32'h1, {31'h0, err});
    cmp_word("unmapped data", 32'h0, rd);
    cmp_word("pready", 32'h1, {31'h0, pready});
    final_report();
  end
endmodule : tb
